// file: acs_adc_control_sequencer.sv
// converter control sequencer: registers, prescaler, conversion timing and result pair
// assumes the analog core samples when sample pulses and offers its code in that same cycle, when the result is latched
//
// Implementation choice: the Avalon-MM slave port.
`include "acs_map.svh"
`timescale 1ns/1ps
`default_nettype none
module acs_adc_control_sequencer
  import acs_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic [9:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  input  wire logic [7:0]  triggerSources,
  input  wire logic        globalIrqEnable,
  input  wire logic        irqAck,
  output logic             conversionIrq,
  input  wire logic [9:0]  analogCode,
  output logic             converterPowered,
  output logic             sampleStrobe,
  output logic [3:0]       activeChannel,
  output logic [1:0]       activeReference,
  output logic             sensorSelected,
  output logic             bandgapSelected,
  output logic             groundSelected,
  output logic             externalSelected
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] ctrl_q;
  logic [7:0] chanRef_q;
  logic [2:0] trigSel_q;
  logic [9:0] result_q;
  logic       lowRead_q;
  logic       ack_q;
  logic [7:0] trigSync1_q;
  logic [7:0] trigSync2_q;
  logic       trigLevel_q;
  logic [6:0] presc_q;
  logic [4:0] cycle_q;
  logic       firstPending_q;
  acs_state_e state_q;
  logic [3:0] activeChannel_q;
  logic [1:0] activeReference_q;
  logic [31:0] readdata_q;
  logic [7:0]  rdByte;

  wire        busReq   = read | write;
  wire [7:0]  regIdx   = address[9:2];
  // writes land on the edge where waitrequest is seen low, as the master expects
  wire        wrLane0  = write & ack_q & byteenable[0];
  wire        wrCtrl   = wrLane0 & (regIdx == `ACS_IDX_CTRL_STATUS);
  wire        wrChan   = wrLane0 & (regIdx == `ACS_IDX_CHAN_REF);
  wire        wrTrig   = wrLane0 & (regIdx == `ACS_IDX_TRIG_SELECT);
  wire        rdLow    = read & ~ack_q & (regIdx == `ACS_IDX_RESULT_LOW);
  wire        rdHigh   = read & ~ack_q & (regIdx == `ACS_IDX_RESULT_HIGH);
  wire [7:0]  wdat     = writedata[7:0];
  wire        enabled  = ctrl_q[`ACS_BIT_ENABLE];
  wire        enNext   = wrCtrl ? wdat[`ACS_BIT_ENABLE] : enabled;
  wire        converting = (state_q == ACS_CONVERT);

  // one wait state: request taken on the edge waitrequest is low
  assign waitrequest = busReq & ~ack_q;

  ////////////////////////////////////////////////////////////////////////////
  // prescaler: tick every 2^k system clocks for divider field k, every 2 for field 0
  logic [6:0] prescMask;
  always_comb
  begin
    unique case (ctrl_q[2:0])
      3'h0, 3'h1: prescMask = 7'h01;
      3'h2:       prescMask = 7'h03;
      3'h3:       prescMask = 7'h07;
      3'h4:       prescMask = 7'h0F;
      3'h5:       prescMask = 7'h1F;
      3'h6:       prescMask = 7'h3F;
      3'h7:       prescMask = 7'h7F;
    endcase
  end
  wire adcTick = enabled & ((presc_q & prescMask) == prescMask);

  ////////////////////////////////////////////////////////////////////////////
  // trigger edge detect on synchronised sources
  wire trigSel     = trigSync2_q[trigSel_q];
  wire freeRun     = (trigSel_q == 3'h0);
  // free running restarts on each finish, whatever the done flag holds; switching to it never edges
  wire trigInput   = freeRun ? 1'b0 : trigSel;
  wire trigEdge    = ctrl_q[`ACS_BIT_AUTO_TRIG] & trigInput & ~trigLevel_q;

  wire swStart     = wrCtrl & wdat[`ACS_BIT_START] & enNext;
  wire cycleLimit  = (cycle_q == ((firstPending_q) ? `ACS_FIRST_CYCLES - 5'd1
                                                   : `ACS_NORMAL_CYCLES - 5'd1));
  wire finish      = converting & adcTick & cycleLimit;
  wire autoRestart = finish & ctrl_q[`ACS_BIT_AUTO_TRIG] & freeRun;
  wire startReq    = enNext & ~converting & (swStart | trigEdge);
  wire frozen      = lowRead_q & ~rdHigh;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      ack_q <= 1'b0;
      presc_q <= 7'h00;
      trigSync1_q <= 8'h00;
      trigSync2_q <= 8'h00;
      trigLevel_q <= 1'b0;
      trigSel_q <= 3'h0;
      chanRef_q <= `ACS_RESET_BYTE;
      lowRead_q <= 1'b0;
      readdata_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= busReq & ~ack_q;
      presc_q <= enabled ? presc_q + 7'h01 : 7'h00;
      trigSync1_q <= triggerSources;
      trigSync2_q <= trigSync1_q;
      trigLevel_q <= trigInput;
      if (wrTrig)
        trigSel_q <= wdat[2:0];
      if (wrChan)
        chanRef_q <= {wdat[7:5], 1'b0, wdat[3:0]};
      if (rdLow)
        lowRead_q <= 1'b1;
      else if (rdHigh)
        lowRead_q <= 1'b0;
      if (read & ~ack_q)
        readdata_q <= {24'h00_0000, rdByte};
    end
  end

  // conversion sequencer
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      state_q <= ACS_IDLE;
      cycle_q <= 5'd0;
      firstPending_q <= 1'b1;
      activeChannel_q <= 4'h0;
      activeReference_q <= 2'h0;
    end
    else if (!enNext)
    begin
      state_q <= ACS_IDLE;
      cycle_q <= 5'd0;
      firstPending_q <= 1'b1;
    end
    else if (startReq | autoRestart)
    begin
      state_q <= ACS_CONVERT;
      cycle_q <= 5'd0;
      if (finish)
        firstPending_q <= 1'b0;
      activeChannel_q <= wrChan ? wdat[3:0] : chanRef_q[3:0];
      activeReference_q <= wrChan ? wdat[7:6] : chanRef_q[7:6];
    end
    else if (finish)
    begin
      state_q <= ACS_IDLE;
      cycle_q <= 5'd0;
      firstPending_q <= 1'b0;
    end
    else if (converting & adcTick)
      cycle_q <= cycle_q + 5'd1;
  end

  // control register: done flag set wins over a clear
  logic [7:0] ctrlNext;
  always_comb
  begin
    ctrlNext = ctrl_q;
    if (wrCtrl)
    begin
      ctrlNext[7] = wdat[7];
      ctrlNext[5] = wdat[5];
      ctrlNext[3:0] = wdat[3:0];
      if (wdat[`ACS_BIT_DONE])
        ctrlNext[`ACS_BIT_DONE] = 1'b0;
    end
    if (irqAck)
      ctrlNext[`ACS_BIT_DONE] = 1'b0;
    if (finish)
      ctrlNext[`ACS_BIT_DONE] = 1'b1;
    ctrlNext[`ACS_BIT_START] = startReq | autoRestart | (converting & ~finish & enNext);
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      ctrl_q <= `ACS_RESET_BYTE;
      result_q <= 10'h000;
    end
    else
    begin
      ctrl_q <= ctrlNext;
      if (finish & ~frozen)
        result_q <= analogCode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path; justification applied at read time
  wire        leftAdj = chanRef_q[`ACS_BIT_LEFT_ADJ];
  wire [15:0] resWord = leftAdj ? {result_q, 6'h00} : {6'h00, result_q};
  always_comb
  begin
    unique case (regIdx)
      `ACS_IDX_RESULT_LOW:  rdByte = resWord[7:0];
      `ACS_IDX_RESULT_HIGH: rdByte = resWord[15:8];
      `ACS_IDX_CTRL_STATUS: rdByte = ctrl_q;
      `ACS_IDX_TRIG_SELECT: rdByte = {5'h00, trigSel_q};
      `ACS_IDX_CHAN_REF:    rdByte = chanRef_q;
      default:              rdByte = 8'h00;
    endcase
  end

  assign readdata = readdata_q;
  assign conversionIrq = ctrl_q[`ACS_BIT_DONE] & ctrl_q[`ACS_BIT_IRQ_EN] & globalIrqEnable;
  assign converterPowered = enabled;
  assign sampleStrobe = finish;
  assign activeChannel = activeChannel_q;
  assign activeReference = activeReference_q;
  assign sensorSelected = (activeChannel_q == `ACS_CHAN_SENSOR);
  assign bandgapSelected = (activeChannel_q == `ACS_CHAN_BANDGAP);
  assign groundSelected = (activeChannel_q == `ACS_CHAN_GROUND);
  assign externalSelected = ~activeChannel_q[3];

  ////////////////////////////////////////////////////////////////////////////
  sequence doneSet_s;
    finish ##1 ctrl_q[`ACS_BIT_DONE];
  endsequence

  doneSets_a: assert property (@(posedge clock) disable iff (!reset_n)
    finish |-> ##1 ctrl_q[`ACS_BIT_DONE]) else $error("done flag not set");
  irqGate_a: assert property (@(posedge clock) disable iff (!reset_n)
    conversionIrq == (ctrl_q[4] & ctrl_q[3] & globalIrqEnable)) else $error("irq gate wrong");
  ackClear_a: assert property (@(posedge clock) disable iff (!reset_n)
    (irqAck & ~finish) |=> !ctrl_q[`ACS_BIT_DONE]) else $error("ack did not clear flag");
  abortOff_a: assert property (@(posedge clock) disable iff (!reset_n)
    (wrCtrl & ~wdat[7]) |=> (state_q == ACS_IDLE) && !ctrl_q[6]) else $error("no abort");
  busyRead_a: assert property (@(posedge clock) disable iff (!reset_n)
    converting |-> ctrl_q[`ACS_BIT_START]) else $error("start bit low while busy");
  resultLoad_a: assert property (@(posedge clock) disable iff (!reset_n)
    (finish & ~frozen) |=> result_q == $past(analogCode)) else $error("result not loaded");
  freezeHold_a: assert property (@(posedge clock) disable iff (!reset_n)
    frozen |=> $stable(result_q)) else $error("result changed while frozen");
  bit4Zero_a: assert property (@(posedge clock) disable iff (!reset_n)
    !chanRef_q[4]) else $error("reserved bit set");
  noTickNoCount_a: assert property (@(posedge clock) disable iff (!reset_n)
    (converting & ~adcTick & ~startReq & enNext) |=> $stable(cycle_q)) else $error("count w/o tick");
  firstLong_a: assert property (@(posedge clock) disable iff (!reset_n)
    (finish & firstPending_q) |-> cycle_q == 5'd24) else $error("first conversion length");
  freeRestart_a: assert property (@(posedge clock) disable iff (!reset_n)
    autoRestart & enNext |=> converting) else $error("free run did not restart");
  doneSeq_a: assert property (@(posedge clock) disable iff (!reset_n)
    (finish & ~irqAck) |-> doneSet_s) else $error("done sequence broken");
endmodule : acs_adc_control_sequencer
`default_nettype wire

// file: acs_map.svh
// register offsets, field positions, reset values and timing counts of the converter sequencer
// assumes byte-addressed avalon-mm; printed offsets are not all multiples of four, so they are indices
// Operation
// - result code is vin times 1024 over vref, 0x3FF is full scale minus one step
// - result pair holds the new result once the done flag is high
// - channel code 1000 routes the temperature sensor to the converter
// - codes 0000-0111 external inputs, 1110 bandgap, 1111 ground, others reserved
// - channel change during a conversion applies only after it completes
// - reference field bits 7:6 decodes four options, latched per conversion
// - left adjust bit 5 alters data presentation immediately
// - bit 4 of the select register always reads zero
// - enable bit 7 powers on; clearing it aborts any conversion
// - start bit begins one conversion; in free running only the first
// - first conversion after enable lasts 25 converter clocks, later ones 13
// - start bit reads one while converting; writing zero has no effect
// - auto trigger enable bit 5 starts a conversion on each trigger rising edge
// - done flag bit 4 sets when a conversion finishes and data is updated; the code also sets it when a frozen pair skips the update
// - interrupt request when done flag, irq enable bit 3 and global enable set
// - done flag cleared by vector acknowledge or by writing one
// - divider field gives 2,2,4,8,16,32,64,128
// - after low byte read, result pair frozen until high byte read
// - switching trigger source to free running makes no trigger edge
`ifndef ACS_MAP_SVH
`define ACS_MAP_SVH
`define ACS_IDX_RESULT_LOW    8'h78
`define ACS_IDX_RESULT_HIGH   8'h79
`define ACS_IDX_CTRL_STATUS   8'h7A
`define ACS_IDX_TRIG_SELECT   8'h7B
`define ACS_IDX_CHAN_REF      8'h7C
`define ACS_BIT_ENABLE        7
`define ACS_BIT_START         6
`define ACS_BIT_AUTO_TRIG     5
`define ACS_BIT_DONE          4
`define ACS_BIT_IRQ_EN        3
`define ACS_BIT_LEFT_ADJ      5
`define ACS_RESET_BYTE        8'h00
`define ACS_FIRST_CYCLES      5'd25
`define ACS_NORMAL_CYCLES     5'd13
`define ACS_CHAN_SENSOR       4'h8
`define ACS_CHAN_BANDGAP      4'hE
`define ACS_CHAN_GROUND       4'hF
`endif

// file: acs_pkg.sv
// types of the converter sequencer
// assumes nothing beyond the map header
package acs_pkg;
  typedef enum logic [1:0] {ACS_IDLE, ACS_CONVERT} acs_state_e;
  typedef enum logic [1:0] {ACS_REF_EXTERNAL, ACS_REF_SUPPLY, ACS_REF_RESERVED,
                            ACS_REF_INTERNAL} acs_ref_e;
endpackage : acs_pkg

// file: acs_core_model.sv
// stand-in for the analog input mux and the converter core
// assumes the sequencer latches channel and reference before each conversion
`timescale 1ns/1ps
`default_nettype none
module acs_core_model
  import acs_pkg::*;
(
  input  wire logic [3:0] activeChannel,
  input  wire logic [1:0] activeReference,
  output logic [9:0]      analogCode
);
  int vinMv;
  int vrefMv;
  int rawCode;
  ////////////////////////////////////////////////////////////////////////////////
  // inputs above the reference saturate at the top code, as a real core would
  always_comb
  begin
    vinMv   = (activeChannel < 4'h8) ? 300 * activeChannel + 120 :
              (activeChannel == 4'h8) ? 352 : (activeChannel == 4'hE) ? 1100 : 0;
    vrefMv  = (activeReference == 2'h3) ? 1100 : (activeReference == 2'h1) ? 5000 : 3300;
    rawCode = vinMv * 1024 / vrefMv;
    analogCode = (rawCode > 1023) ? 10'h3FF : rawCode[9:0];
  end
endmodule : acs_core_model
`default_nettype wire

// file: tb_top.sv
// self-checking bench of the converter sequencer
// assumes the map header, the package and the core stand-in are compiled first
`include "acs_map.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) \
  begin cmp_count++; if ((a) !== (b)) begin error_cnt++; \
  $display("wrong value at %0t: %0h not %0h", $time, (a), (b)); end end
module tb_top;
  import acs_pkg::*;
  logic        clock, reset_n, read, write, waitrequest, globalIrqEnable, irqAck;
  logic        conversionIrq, converterPowered, sampleStrobe, sensorSelected;
  logic        bandgapSelected, groundSelected, externalSelected;
  logic [9:0]  address, analogCode;
  logic [31:0] writedata, readdata;
  logic [7:0]  triggerSources, rd;
  logic [3:0]  activeChannel;
  logic [1:0]  activeReference;
  logic [15:0] v;
  int          error_cnt, cmp_count, strobeCnt, n0, ch, rf;
  int          seed = 32'h007B7DF8;
  int          chs[11] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 14, 15};
  time         t0, tS;
  acs_adc_control_sequencer acs_adc_control_sequencer_inst (.clock, .reset_n, .address, .read,
    .write, .writedata, .byteenable(4'hF), .readdata, .waitrequest, .triggerSources,
    .globalIrqEnable, .irqAck, .conversionIrq, .analogCode, .converterPowered, .sampleStrobe,
    .activeChannel, .activeReference, .sensorSelected, .bandgapSelected, .groundSelected,
    .externalSelected);
  acs_core_model acs_core_model_inst (.activeChannel, .activeReference, .analogCode);
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  always @(posedge clock)
    if (sampleStrobe === 1'b1)
    begin
      strobeCnt++;
      tS = $time;
    end
  ////////////////////////////////////////////////////////////////////////////////
  task final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  // holds the request until waitrequest is seen low, then one idle edge
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    address <= {idx, 2'b00};
    writedata <= {24'h000000, wd};
    write <= wr;
    read <= !wr;
    @(posedge clock);
    t0 = $time;
    for (n = 0; n < 20 && waitrequest !== 1'b0; n++) @(posedge clock);
    rd = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
    if (n == 20)
    begin
      error_cnt++;
      final_report();
    end
    @(posedge clock);
  endtask : bus
  task automatic waitStrobe(input int cnt, input int lim);
    int k;
    for (k = 0; k < lim && strobeCnt <= cnt; k++) @(posedge clock);
    if (k == lim)
    begin
      $display("wrong value at %0t: conversion never ended", $time);
      error_cnt++;
      final_report();
    end
  endtask : waitStrobe
  task automatic conv(input logic [7:0] ctrl, input int ticks, input int div);
    int  cnt;
    int  dur;
    time tW;
    cnt = strobeCnt;
    bus(1'b1, `ACS_IDX_CTRL_STATUS, ctrl);
    tW = t0;
    bus(1'b0, `ACS_IDX_CTRL_STATUS, 8'h00);
    `CHK(rd[6], 1'b1)
    waitStrobe(cnt, 5000);
    dur = int'((tS - tW) / 50);
    `CHK(dur >= (ticks - 1) * div + 1 && dur <= ticks * div + 4, 1'b1)
    repeat (3) @(posedge clock);
    bus(1'b0, `ACS_IDX_CTRL_STATUS, 8'h00);
    `CHK({rd[6], rd[4]}, 2'b01)
  endtask : conv
  task automatic readPair(output logic [15:0] pair);
    logic [7:0] lo;
    bus(1'b0, `ACS_IDX_RESULT_LOW, 8'h00);
    lo = rd;
    bus(1'b0, `ACS_IDX_RESULT_HIGH, 8'h00);
    pair = {rd, lo};
  endtask : readPair
  // independent reckoning of the ideal code for the stand-in's input voltages
  function automatic int expc(input int c, input int r);
    int vin;
    int ref_mv;
    vin = c < 8 ? 300 * c + 120 : c == 8 ? 352 : c == 14 ? 1100 : 0;
    ref_mv = r == 3 ? 1100 : r == 1 ? 5000 : 3300;
    return (vin * 1024 / ref_mv > 1023) ? 1023 : vin * 1024 / ref_mv;
  endfunction : expc
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {reset_n, read, write, globalIrqEnable, irqAck} = 5'h00;
    {address, writedata, triggerSources} = '0;
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    bus(1'b0, `ACS_IDX_CTRL_STATUS, 8'h00);
    `CHK(rd, 8'h00)
    bus(1'b0, 8'h10, 8'h00);
    `CHK(rd, 8'h00)
    bus(1'b1, `ACS_IDX_CHAN_REF, 8'hFF);
    bus(1'b0, `ACS_IDX_CHAN_REF, 8'h00);
    `CHK(rd, 8'hEF)
    $display("test registers done");
    for (int i = 0; i < 11; i++)
    begin
      ch = chs[i];
      rf = (ch == 8) ? 3 : $unsigned($random(seed)) % 3;
      bus(1'b1, `ACS_IDX_CHAN_REF, 8'(rf * 64 + ch));
      conv(8'hC0, (i == 0) ? 25 : 13, 2);
      `CHK({sensorSelected, bandgapSelected, groundSelected, externalSelected}, {ch == 8, ch == 14, ch == 15, ch < 8})
      `CHK({activeReference, activeChannel}, 6'(rf * 16 + ch))
      readPair(v);
      `CHK(v, 16'(expc(ch, rf)))
      bus(1'b1, `ACS_IDX_CHAN_REF, 8'(rf * 64 + 32 + ch));
      readPair(v);
      `CHK(v, 16'(expc(ch, rf) << 6))
      bus(1'b1, `ACS_IDX_CTRL_STATUS, 8'h90);
      bus(1'b0, `ACS_IDX_CTRL_STATUS, 8'h00);
      `CHK(rd[4], 1'b0)
    end
    $display("test channels done");
    for (int c = 1; c < 8; c++) conv(8'hC0 | 8'(c), 13, c < 2 ? 2 : 1 << c);
    $display("test divider done");
    bus(1'b1, `ACS_IDX_CHAN_REF, 8'h41);
    n0 = strobeCnt;
    bus(1'b1, `ACS_IDX_CTRL_STATUS, 8'hC4);
    bus(1'b1, `ACS_IDX_CHAN_REF, 8'hC6);
    `CHK({activeReference, activeChannel}, 6'h11)
    waitStrobe(n0, 1000);
    repeat (3) @(posedge clock);
    readPair(v);
    `CHK(v, 16'(expc(1, 1)))
    conv(8'hC0, 13, 2);
    `CHK({activeReference, activeChannel}, 6'h36)
    bus(1'b1, `ACS_IDX_CHAN_REF, 8'h43);
    conv(8'hD0, 13, 2);
    bus(1'b0, `ACS_IDX_RESULT_LOW, 8'h00);
    bus(1'b1, `ACS_IDX_CHAN_REF, 8'h45);
    n0 = strobeCnt;
    bus(1'b1, `ACS_IDX_CTRL_STATUS, 8'hC0);
    waitStrobe(n0, 100);
    bus(1'b0, `ACS_IDX_RESULT_HIGH, 8'h00);
    `CHK(rd, 8'(expc(3, 1) >> 8))
    $display("test latching done");
    globalIrqEnable <= 1'b1;
    conv(8'hC8, 13, 2);
    `CHK(conversionIrq, 1'b1)
    globalIrqEnable <= 1'b0;
    @(posedge clock);
    `CHK(conversionIrq, 1'b0)
    irqAck <= 1'b1;
    @(posedge clock);
    irqAck <= 1'b0;
    @(posedge clock);
    bus(1'b0, `ACS_IDX_CTRL_STATUS, 8'h00);
    `CHK(rd[4], 1'b0)
    $display("test interrupt done");
    n0 = strobeCnt;
    bus(1'b1, `ACS_IDX_CTRL_STATUS, 8'hC7);
    bus(1'b1, `ACS_IDX_CTRL_STATUS, 8'h87);
    bus(1'b0, `ACS_IDX_CTRL_STATUS, 8'h00);
    `CHK(rd[6], 1'b1)
    bus(1'b1, `ACS_IDX_CTRL_STATUS, 8'h07);
    `CHK(converterPowered, 1'b0)
    repeat (2000) @(posedge clock);
    `CHK(strobeCnt == n0, 1'b1)
    conv(8'hC0, 25, 2);
    $display("test abort done");
    bus(1'b1, `ACS_IDX_TRIG_SELECT, 8'h00);
    n0 = strobeCnt;
    bus(1'b1, `ACS_IDX_CTRL_STATUS, 8'hE0);
    waitStrobe(n0 + 2, 200);
    `CHK(strobeCnt >= n0 + 3, 1'b1)
    bus(1'b1, `ACS_IDX_CTRL_STATUS, 8'h00);
    bus(1'b1, `ACS_IDX_TRIG_SELECT, 8'h01);
    bus(1'b1, `ACS_IDX_CTRL_STATUS, 8'hA0);
    n0 = strobeCnt;
    repeat (100) @(posedge clock);
    `CHK(strobeCnt == n0, 1'b1)
    triggerSources <= 8'h02;
    waitStrobe(n0, 200);
    `CHK(strobeCnt == n0 + 1, 1'b1)
    n0 = strobeCnt;
    bus(1'b1, `ACS_IDX_TRIG_SELECT, 8'h00);
    repeat (100) @(posedge clock);
    `CHK(strobeCnt == n0, 1'b1)
    $display("test triggering done");
    final_report();
  end
endmodule : tb_top
`default_nettype wire
